/* File: hdl/sppe_pkg.sv */
// Notes on behaviour
// - Decrementing pop copies indirect source to destination
// - Then user pointer drops by exactly one
// - No status flag changes for these instructions
// - Incrementing pop loads destination, then pointer+1
// - Push: decrement stack pointer, then store source
// - Indirect push stores the addressed register's contents
// - Stack pointer decrements as 16 bits, wrapping
package sppe_pkg;
  // ============================================================
  // Opcodes
  localparam logic [7:0] OPC_POP_USER_STACK_DEC = 8'h92;
  localparam logic [7:0] OPC_POP_USER_STACK_INC = 8'h93;
  localparam logic [7:0] OPC_PUSH_DIRECT        = 8'h70;
  localparam logic [7:0] OPC_PUSH_INDIRECT      = 8'h71;
  // ============================================================
  // Timing and reset values
  localparam int         INSTR_CYCLES    = 8;
  localparam logic [7:0] SP_HIGH_RESET   = 8'h00;
  localparam logic [7:0] SP_LOW_RESET    = 8'h00;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] BYTE_ONE        = 8'h01;
  localparam logic [15:0] WORD_ONE       = 16'h0001;
  localparam logic [7:0] FLAG_WRITE_NONE = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_PTR, ST_RD_DATA, ST_WR_DST, ST_WR_PTR,
    ST_RD_SRC, ST_RD_IND, ST_PUSH, ST_WAIT
  } sppe_state_t;

  // Modulo-256 step of an 8-bit pointer
  function automatic logic [7:0] sppe_step8(input logic [7:0] v,
                                            input logic       up);
    sppe_step8 = up ? 8'(v + BYTE_ONE) : 8'(v - BYTE_ONE);
  endfunction
endpackage

/* File: hdl/sppe_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sppe_tick_if;
  logic start;
  logic last;
  modport ctrl  (output start, input last);
  modport timer (input start, output last);
endinterface
`default_nettype wire

/* File: hdl/sppe_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sppe_timer #(
  parameter int CYCLES = sppe_pkg::INSTR_CYCLES
) (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  sppe_tick_if.timer  tick
);
  import sppe_pkg::*;
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // ============================================================
  // Cycle count within one instruction
  always_comb begin
    if (tick.start) begin
      next_cnt = BYTE_ZERO;
    end else if (cnt != 8'hFF) begin
      next_cnt = 8'(cnt + BYTE_ONE);
    end else begin
      next_cnt = cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'hFF;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Saturated count keeps last quiet when idle
  assign tick.last = (cnt == 8'(CYCLES - 1));
endmodule
`default_nettype wire

/* File: hdl/sppe_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module sppe_exec #(
  parameter int INSTR_CYCLES = sppe_pkg::INSTR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_opcode,
  input  wire logic [7:0]  instr_byte1,
  input  wire logic [7:0]  instr_byte2,
  output logic             busy,
  output logic             done,
  output logic             rf_rd_en,
  output logic [7:0]       rf_rd_addr,
  input  wire logic [7:0]  rf_rdata,
  output logic             rf_wr_en,
  output logic [7:0]       rf_wr_addr,
  output logic [7:0]       rf_wr_data,
  output logic             stack_wr_en,
  output logic [15:0]      stack_wr_addr,
  output logic [7:0]       stack_wr_data,
  output logic [7:0]       stack_pointer_high,
  output logic [7:0]       stack_pointer_low,
  output logic [7:0]       flag_wr_en
);
  import sppe_pkg::*;

  // ============================================================
  // Reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ============================================================
  // Instruction timer
  sppe_tick_if tick ();
  sppe_timer #(.CYCLES(INSTR_CYCLES)) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  // ============================================================
  // Sequencer state
  sppe_state_t state;
  sppe_state_t next_state;
  logic [7:0]  opc;
  logic [7:0]  next_opc;
  logic [7:0]  src;
  logic [7:0]  next_src;
  logic [7:0]  dst;
  logic [7:0]  next_dst;
  logic [7:0]  uptr;
  logic [7:0]  next_uptr;
  logic [7:0]  next_sph;
  logic [7:0]  next_spl;
  logic        next_rf_wr_en;
  logic [7:0]  next_rf_wr_addr;
  logic [7:0]  next_rf_wr_data;
  logic        next_stack_wr_en;
  logic [15:0] next_stack_wr_addr;
  logic [7:0]  next_stack_wr_data;
  logic [15:0] sp_dec;
  logic        accept;
  logic        known;

  assign known = (instr_opcode == OPC_POP_USER_STACK_DEC) ||
                 (instr_opcode == OPC_POP_USER_STACK_INC) ||
                 (instr_opcode == OPC_PUSH_DIRECT) ||
                 (instr_opcode == OPC_PUSH_INDIRECT);
  // Other opcodes belong to other units and are ignored here
  assign accept = (state == ST_IDLE) && instr_valid && known;
  assign tick.start = accept;

  assign sp_dec = 16'({stack_pointer_high, stack_pointer_low} - WORD_ONE);

  always_comb begin
    next_state         = state;
    next_opc           = opc;
    next_src           = src;
    next_dst           = dst;
    next_uptr          = uptr;
    next_sph           = stack_pointer_high;
    next_spl           = stack_pointer_low;
    next_rf_wr_en      = 1'b0;
    next_rf_wr_addr    = rf_wr_addr;
    next_rf_wr_data    = rf_wr_data;
    next_stack_wr_en   = 1'b0;
    next_stack_wr_addr = stack_wr_addr;
    next_stack_wr_data = stack_wr_data;
    rf_rd_en           = 1'b0;
    rf_rd_addr         = BYTE_ZERO;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_opc = instr_opcode;
          next_src = instr_byte1;
          next_dst = instr_byte2;
          if (instr_opcode == OPC_PUSH_DIRECT ||
              instr_opcode == OPC_PUSH_INDIRECT) begin
            next_state = ST_RD_SRC;
          end else begin
            next_state = ST_RD_PTR;
          end
        end
      end
      ST_RD_PTR: begin
        rf_rd_en   = 1'b1;
        rf_rd_addr = src;
        next_state = ST_RD_DATA;
      end
      ST_RD_DATA: begin
        // Pointer arrives now; fetch what it addresses
        next_uptr  = rf_rdata;
        rf_rd_en   = 1'b1;
        rf_rd_addr = rf_rdata;
        next_state = ST_WR_DST;
      end
      ST_WR_DST: begin
        next_rf_wr_en   = 1'b1;
        next_rf_wr_addr = dst;
        next_rf_wr_data = rf_rdata;
        next_state      = ST_WR_PTR;
      end
      ST_WR_PTR: begin
        next_rf_wr_en   = 1'b1;
        next_rf_wr_addr = src;
        next_rf_wr_data = sppe_step8(uptr,
                            opc == OPC_POP_USER_STACK_INC);
        next_state      = ST_WAIT;
      end
      ST_RD_SRC: begin
        rf_rd_en   = 1'b1;
        rf_rd_addr = src;
        if (opc == OPC_PUSH_INDIRECT) begin
          next_state = ST_RD_IND;
        end else begin
          next_state = ST_PUSH;
        end
      end
      ST_RD_IND: begin
        rf_rd_en   = 1'b1;
        rf_rd_addr = rf_rdata;
        next_state = ST_PUSH;
      end
      ST_PUSH: begin
        // decrement, then store at new pointer
        next_sph           = sp_dec[15:8];
        next_spl           = sp_dec[7:0];
        next_stack_wr_en   = 1'b1;
        next_stack_wr_addr = sp_dec;
        next_stack_wr_data = rf_rdata;
        next_state         = ST_WAIT;
      end
      ST_WAIT: begin
        // Pads every instruction to its fixed cycle count
        if (tick.last) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      opc                <= BYTE_ZERO;
      src                <= BYTE_ZERO;
      dst                <= BYTE_ZERO;
      uptr               <= BYTE_ZERO;
      stack_pointer_high <= SP_HIGH_RESET;
      stack_pointer_low  <= SP_LOW_RESET;
      rf_wr_en           <= 1'b0;
      rf_wr_addr         <= BYTE_ZERO;
      rf_wr_data         <= BYTE_ZERO;
      stack_wr_en        <= 1'b0;
      stack_wr_addr      <= {BYTE_ZERO, BYTE_ZERO};
      stack_wr_data      <= BYTE_ZERO;
    end else begin
      state              <= next_state;
      opc                <= next_opc;
      src                <= next_src;
      dst                <= next_dst;
      uptr               <= next_uptr;
      stack_pointer_high <= next_sph;
      stack_pointer_low  <= next_spl;
      rf_wr_en           <= next_rf_wr_en;
      rf_wr_addr         <= next_rf_wr_addr;
      rf_wr_data         <= next_rf_wr_data;
      stack_wr_en        <= next_stack_wr_en;
      stack_wr_addr      <= next_stack_wr_addr;
      stack_wr_data      <= next_stack_wr_data;
    end
  end

  assign busy = (state != ST_IDLE);
  assign done = (state == ST_WAIT) && tick.last;
  assign flag_wr_en = FLAG_WRITE_NONE;
endmodule
`default_nettype wire

/* File: dv/sppe_exec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module sppe_exec_chk
  import sppe_pkg::*;
#(
  parameter int INSTR_CYCLES = 8
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_opcode,
  input wire logic [7:0]  instr_byte1,
  input wire logic [7:0]  instr_byte2,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        rf_wr_en,
  input wire logic [7:0]  rf_wr_addr,
  input wire logic        stack_wr_en,
  input wire logic [15:0] stack_wr_addr,
  input wire logic [7:0]  stack_pointer_high,
  input wire logic [7:0]  stack_pointer_low,
  input wire logic [7:0]  flag_wr_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic        go;
  logic [15:0] sp;
  assign go = instr_valid && !busy;
  assign sp = {stack_pointer_high, stack_pointer_low};
  chk_done_eight_cycles: assert property (
    $rose(busy) |-> ##7 done ##1 !busy) else $error("done off time");
  chk_flags_untouched: assert property (
    flag_wr_en == 8'h00) else $error("flag written");
  // Data goes to the destination before the pointer write-back
  chk_pop_dec_writes: assert property (
    go && instr_opcode == OPC_POP_USER_STACK_DEC |=>
    ##3 (rf_wr_en && rf_wr_addr == $past(instr_byte2, 4))
    ##1 (rf_wr_en && rf_wr_addr == $past(instr_byte1, 5))
    ##1 !rf_wr_en) else $error("pop dec write order");
  chk_pop_inc_writes: assert property (
    go && instr_opcode == OPC_POP_USER_STACK_INC |=>
    ##3 (rf_wr_en && rf_wr_addr == $past(instr_byte2, 4))
    ##1 (rf_wr_en && rf_wr_addr == $past(instr_byte1, 5))
    ##1 !rf_wr_en) else $error("pop inc write order");
  chk_push_dec_first: assert property (
    go && instr_opcode == OPC_PUSH_DIRECT |=> !stack_wr_en[*2]
    ##1 stack_wr_en) else $error("push write time");
  chk_push_ind_read: assert property (
    go && instr_opcode == OPC_PUSH_INDIRECT |=> !stack_wr_en[*3]
    ##1 stack_wr_en) else $error("indirect push time");
  chk_sp_wraps: assert property (
    $changed(sp) |-> sp == $past(sp) - 16'h0001) else $error("sp step");
  chk_sp_pair: assert property (
    stack_wr_en |-> sp == stack_wr_addr) else $error("sp bytes apart");
endmodule

bind sppe_exec sppe_exec_chk #(.INSTR_CYCLES(INSTR_CYCLES)) chk_inst (
  .core_clk, .rstn, .instr_valid, .instr_opcode, .instr_byte1,
  .instr_byte2, .busy, .done, .rf_wr_en, .rf_wr_addr,
  .stack_wr_en, .stack_wr_addr, .stack_pointer_high,
  .stack_pointer_low, .flag_wr_en
);
`default_nettype wire

/* File: dv/sppe_rf_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Register file with one-cycle read
module sppe_rf_model (
  input  wire logic       core_clk,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rdata,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  logic [7:0] mem [256];
  initial rdata = 8'h00;
  // Stale data inverted, so a late sample cannot pass
  always @(posedge core_clk) begin
    rdata <= rd_en ? mem[rd_addr] : ~rdata;
    if (wr_en) mem[wr_addr] <= wr_data;
  end
endmodule
`default_nettype wire

/* File: dv/test_stack_push_pop_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module test_stack_push_pop_exec;
  import sppe_pkg::*;
  logic        core_clk, rstn, instr_valid, busy, done;
  logic        rf_rd_en, rf_wr_en, stack_wr_en;
  logic [7:0]  instr_opcode, instr_byte1, instr_byte2, rf_rd_addr;
  logic [7:0]  rf_rdata, rf_wr_addr, rf_wr_data, stack_wr_data;
  logic [7:0]  stack_pointer_high, stack_pointer_low, flag_wr_en;
  logic [15:0] stack_wr_addr;
  int          miscompares, check_count;
  // ============================================================
  // Design and register file
  sppe_exec sppe_exec_inst (
    .core_clk, .rstn, .instr_valid, .instr_opcode, .instr_byte1,
    .instr_byte2, .busy, .done, .rf_rd_en, .rf_rd_addr, .rf_rdata,
    .rf_wr_en, .rf_wr_addr, .rf_wr_data, .stack_wr_en, .stack_wr_addr,
    .stack_wr_data, .stack_pointer_high, .stack_pointer_low, .flag_wr_en
  );
  sppe_rf_model sppe_rf_model_inst (
    .core_clk, .rd_en(rf_rd_en), .rd_addr(rf_rd_addr), .rdata(rf_rdata),
    .wr_en(rf_wr_en), .wr_addr(rf_wr_addr), .wr_data(rf_wr_data)
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ============================================================
  // Tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] a);
    int n;
    instr_valid  = 1'b1;
    instr_opcode = op;
    instr_byte1  = a;
    @(posedge core_clk);
    #1;
    instr_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      end_of_test();
    end
    cmp(16'(n), 16'(INSTR_CYCLES));
    cmp(flag_wr_en, 8'h00);
    // One more edge: busy only drops after the done cycle
    @(posedge core_clk);
    #1;
  endtask
  task automatic pop_dec_wrap;
    sppe_rf_model_inst.mem[8'h20] = 8'h00;
    sppe_rf_model_inst.mem[8'h00] = 8'h5a;
    instr_byte2 = 8'h02;
    run(OPC_POP_USER_STACK_DEC, 8'h20);
    cmp(sppe_rf_model_inst.mem[8'h02], 8'h5a);
    cmp(sppe_rf_model_inst.mem[8'h20], 8'hff);
  endtask
  task automatic pop_inc_wrap;
    sppe_rf_model_inst.mem[8'h30] = 8'hff;
    sppe_rf_model_inst.mem[8'hff] = 8'h70;
    instr_byte2 = 8'h03;
    run(OPC_POP_USER_STACK_INC, 8'h30);
    cmp(sppe_rf_model_inst.mem[8'h03], 8'h70);
    cmp(sppe_rf_model_inst.mem[8'h30], 8'h00);
  endtask
  task automatic push_pair(input logic [7:0] op, input logic [15:0] sp,
                           input logic [7:0] val);
    sppe_rf_model_inst.mem[8'h40] = 8'h4f;
    sppe_rf_model_inst.mem[8'h4f] = 8'haa;
    run(op, 8'h40);
    cmp({stack_pointer_high, stack_pointer_low}, sp);
    cmp(stack_wr_addr, sp);
    cmp(stack_wr_data, val);
  endtask
  task automatic refuse_unknown;
    instr_valid  = 1'b1;
    instr_opcode = 8'h50;
    repeat (3) begin
      @(posedge core_clk);
      #1;
      cmp(busy, 1'b0);
    end
    instr_valid = 1'b0;
  endtask
  initial begin
    rstn         = 1'b0;
    instr_valid  = 1'b0;
    instr_opcode = 8'h00;
    instr_byte1  = 8'h00;
    instr_byte2  = 8'h00;
    miscompares  = 0;
    check_count  = 0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    pop_dec_wrap();
    pop_inc_wrap();
    push_pair(OPC_PUSH_DIRECT, 16'hffff, 8'h4f);
    push_pair(OPC_PUSH_INDIRECT, 16'hfffe, 8'haa);
    refuse_unknown();
    end_of_test();
  end
endmodule
`default_nettype wire
